// ===== hdl/wkt_pin_sync.sv
/*
 * Two-stage synchroniser for the oscillator pin plus a rising-edge pulse.
 * Assumes the pin is slow against the system clock.
 */
module wkt_pin_sync
    import wkt_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic pinLevel,
    output logic risePulse
);
    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    // edge detect looks only at stage2/stage3, never at the first stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
        end else if (clockEnable) begin
            stage1_q <= pinLevel;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    assign risePulse = stage2_q & ~stage3_q;
endmodule

// ===== hdl/wkt_prescaler.sv
/*
 * Divides oscillator edges by 1, 8, 16 or 32 into one-cycle ticks.
 * Assumes lfoRise is a one-cycle pulse per oscillator period.
 */
`include "wkt_regs.svh"
module wkt_prescaler
    import wkt_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic lfoRise,
    input wire logic [1:0] clockSelect,
    output logic tick
);
    logic [4:0] divCount_q;
    logic [4:0] divLast;
    logic tick_q;

    always_comb begin
        unique case (clockSelect)
            2'h0: divLast = `WKT_DIV_1_LAST;
            2'h1: divLast = `WKT_DIV_8_LAST;
            2'h2: divLast = `WKT_DIV_16_LAST;
            2'h3: divLast = `WKT_DIV_32_LAST;
        endcase
    end

    // a select change mid-period finishes on the new limit, or at the next edge if already past it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            divCount_q <= 5'h00;
            tick_q <= 1'b0;
        end else if (clockEnable) begin
            tick_q <= 1'b0;
            if (lfoRise) begin
                if (divCount_q >= divLast) begin
                    divCount_q <= 5'h00;
                    tick_q <= 1'b1;
                end else begin
                    divCount_q <= divCount_q + 5'h01;
                end
            end
        end
    end

    assign tick = tick_q;
endmodule

// ===== hdl/wkt_wake_timer.sv
/*
 * Wake-up timer: APB register file, 16-bit down counter, card presence
 * scan sequencer and interrupt. Assumes an external timer 3 times the RF
 * window and the scan front end reports cardPresent on the system clock.
 */
// Local design decision: the APB slave port.
`include "wkt_regs.svh"
module wkt_wake_timer
    import wkt_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic lfoClockPin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer3Expired,
    input wire logic cardPresent,
    output wkt_sys_s systemEvents,
    output logic irq
);
    // ------------------------------------------------------------
    // clock and prescaler
    // ------------------------------------------------------------
    logic lfoRise;
    logic tick;
    wkt_ctrl_s ctrl_q;

    wkt_pin_sync pinSync (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .pinLevel(lfoClockPin),
        .risePulse(lfoRise)
    );

    wkt_prescaler prescaler (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .lfoRise(lfoRise),
        .clockSelect(ctrl_q.wakeTimerClockSelect),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [7:0] regIndex;
    logic aligned;
    logic setupPhase;
    logic accessWrite;
    logic hitCtrl, hitRelHi, hitRelLo, hitCntHi, hitCntLo;
    logic hitStatus, hitMask, hitScan, hitAny;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] readData;

    assign regIndex = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite & pready_q;
    assign hitCtrl = aligned && regIndex == `WKT_IDX_CTRL;
    assign hitRelHi = aligned && regIndex == `WKT_IDX_RELOAD_HI;
    assign hitRelLo = aligned && regIndex == `WKT_IDX_RELOAD_LO;
    assign hitCntHi = aligned && regIndex == `WKT_IDX_COUNT_HI;
    assign hitCntLo = aligned && regIndex == `WKT_IDX_COUNT_LO;
    assign hitStatus = aligned && regIndex == `WKT_IDX_IRQ_STATUS;
    assign hitMask = aligned && regIndex == `WKT_IDX_IRQ_MASK;
    assign hitScan = aligned && regIndex == `WKT_IDX_SCAN_STATUS;
    assign hitAny = hitCtrl | hitRelHi | hitRelLo | hitCntHi | hitCntLo
        | hitStatus | hitMask | hitScan;

    // ------------------------------------------------------------
    // timer core
    // ------------------------------------------------------------
    logic active_q;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic wrCtrl;
    logic startEvent;
    logic stopEvent;
    logic underflow;
    logic restartOnZero;

    assign wrCtrl = accessWrite & hitCtrl;
    // a write moves the running bit only when the qualifier is written as one
    assign startEvent = wrCtrl & pwdata[`WKT_BIT_QUALIFIER]
        & pwdata[`WKT_BIT_ACTIVE] & ~active_q;
    assign stopEvent = wrCtrl & pwdata[`WKT_BIT_QUALIFIER] & ~pwdata[`WKT_BIT_ACTIVE];
    // a reload of zero still underflows on the first tick
    assign underflow = active_q & tick & ~stopEvent & (count_q <= 16'h0001);
    assign restartOnZero = ctrl_q.autoReloadOnZero | ctrl_q.autoCardPresenceScan;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= `WKT_CTRL_RESET;
        end else if (clockEnable && wrCtrl) begin
            ctrl_q <= wkt_ctrl_s'(pwdata[5:0]);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reload_q <= `WKT_RELOAD_RESET;
        end else if (clockEnable) begin
            // stored only; the counter picks it up at the next start or the next restart at zero
            if (accessWrite && hitRelHi) begin
                reload_q[15:8] <= pwdata[7:0];
            end
            if (accessWrite && hitRelLo) begin
                reload_q[7:0] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            active_q <= 1'b0;
        end else if (clockEnable) begin
            if (startEvent) begin
                active_q <= 1'b1;
            end else if (stopEvent) begin
                active_q <= 1'b0;
            end else if (underflow && !restartOnZero) begin
                active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= 16'h0000;
        end else if (clockEnable) begin
            if (startEvent) begin
                count_q <= reload_q;
            end else if (underflow) begin
                count_q <= restartOnZero ? reload_q : 16'h0000;
            end else if (active_q && tick) begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // card presence scan
    // ------------------------------------------------------------
    wkt_scan_e scanState_q;
    wkt_scan_e scanState_d;
    logic scanLaunch;
    logic scanDecide;
    logic scanCard;
    logic scanEmpty;
    logic lastCard_q;

    // an underflow while the field is still on does not relaunch
    assign scanLaunch = underflow & ctrl_q.autoCardPresenceScan
        & (scanState_q == SCAN_IDLE);
    assign scanDecide = (scanState_q == SCAN_FIELD) & timer3Expired;
    assign scanCard = scanDecide & cardPresent;
    assign scanEmpty = scanDecide & ~cardPresent;

    always_comb begin
        scanState_d = scanState_q;
        unique case (scanState_q)
            SCAN_IDLE: begin
                if (scanLaunch) begin
                    scanState_d = SCAN_FIELD;
                end
            end
            SCAN_FIELD: begin
                if (timer3Expired) begin
                    scanState_d = SCAN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            scanState_q <= SCAN_IDLE;
            lastCard_q <= 1'b0;
        end else if (clockEnable) begin
            scanState_q <= scanState_d;
            if (scanDecide) begin
                lastCard_q <= cardPresent;
            end
        end
    end

    // ------------------------------------------------------------
    // system requests
    // ------------------------------------------------------------
    wkt_sys_s events_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            events_q <= '0;
        end else if (clockEnable) begin
            events_q.wakeRequest <= underflow & ctrl_q.autoWakeOnUnderflow;
            events_q.trimStart <= underflow & ctrl_q.autoOscillatorTrim;
            events_q.timer3Start <= scanLaunch;
            events_q.rfFieldOn <= (scanState_d == SCAN_FIELD);
            events_q.powerDownRequest <= scanEmpty & ctrl_q.autoWakeOnUnderflow;
            // stays up on a card, or on an empty scan while auto-wake is cleared
            if (scanLaunch) begin
                events_q.stayActive <= 1'b0;
            end else if (scanCard || (scanEmpty && !ctrl_q.autoWakeOnUnderflow)) begin
                events_q.stayActive <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    wkt_irq_s irqStatus_q;
    wkt_irq_s irqStatus_d;
    wkt_irq_s irqMask_q;
    wkt_irq_s irqSet;
    wkt_irq_s irqClear;
    logic irq_q;

    assign irqSet = '{scanEmpty: scanEmpty, scanCard: scanCard, underflow: underflow};
    assign irqClear = (accessWrite && hitStatus) ? wkt_irq_s'(pwdata[2:0]) : '0;
    // set wins over a same-cycle write-one-to-clear
    assign irqStatus_d = (irqStatus_q & ~irqClear) | irqSet;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irqStatus_q <= `WKT_IRQ_RESET;
            irqMask_q <= `WKT_IRQ_RESET;
            irq_q <= 1'b0;
        end else if (clockEnable) begin
            irqStatus_q <= irqStatus_d;
            if (accessWrite && hitMask) begin
                irqMask_q <= wkt_irq_s'(pwdata[2:0]);
            end
            irq_q <= |(irqStatus_d & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // read data and APB answer
    // ------------------------------------------------------------
    always_comb begin
        readData = 32'h0000_0000;
        if (hitCtrl) begin
            readData[7:0] = {active_q, 1'b0, ctrl_q};
        end else if (hitRelHi) begin
            readData[7:0] = reload_q[15:8];
        end else if (hitRelLo) begin
            readData[7:0] = reload_q[7:0];
        end else if (hitCntHi) begin
            readData[7:0] = count_q[15:8];
        end else if (hitCntLo) begin
            readData[7:0] = count_q[7:0];
        end else if (hitStatus) begin
            readData[2:0] = irqStatus_q;
        end else if (hitMask) begin
            readData[2:0] = irqMask_q;
        end else if (hitScan) begin
            readData[1:0] = {lastCard_q, events_q.rfFieldOn};
        end
    end

    // every access answers after one access-phase cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (clockEnable) begin
            pready_q <= setupPhase;
            pslverr_q <= setupPhase & ~hitAny;
            if (setupPhase && !pwrite) begin
                prdata_q <= readData;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign systemEvents = events_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset || !clockEnable);

    sequence launchSeq;
        clockEnable && underflow && ctrl_q.autoCardPresenceScan && scanState_q == SCAN_IDLE;
    endsequence

    sequence fieldOnSeq;
        events_q.timer3Start && events_q.rfFieldOn;
    endsequence

    a_run_qualified: assert property (wrCtrl && !pwdata[`WKT_BIT_QUALIFIER] && !underflow
        |=> active_q == $past(active_q))
        else $error("running bit changed without qualifier");

    a_start_loads: assert property (startEvent |=> active_q && count_q == $past(reload_q))
        else $error("start did not load reload word");

    a_stop_clears: assert property (stopEvent |=> !active_q)
        else $error("qualified stop did not clear running");

    a_reload_isolated: assert property (active_q && accessWrite && (hitRelHi || hitRelLo)
        && !tick && !startEvent |=> count_q == $past(count_q))
        else $error("reload write disturbed countdown");

    a_oneshot_stop: assert property (underflow && !restartOnZero
        |=> !active_q && count_q == 16'h0000)
        else $error("one-shot did not stop at zero");

    a_restart_nogap: assert property (underflow && restartOnZero
        |=> active_q && count_q == $past(reload_q))
        else $error("restart left a gap or wrong value");

    a_tick_decrement: assert property (active_q && tick && !underflow && !stopEvent
        |=> count_q == $past(count_q) - 16'h0001)
        else $error("count did not step down by one");

    a_flag_underflow: assert property (underflow |=> irqStatus_q.underflow)
        else $error("underflow flag not set");

    a_trim_start: assert property (underflow && ctrl_q.autoOscillatorTrim
        |=> events_q.trimStart ##1 !events_q.trimStart)
        else $error("trim start pulse wrong");

    a_wake_pulse: assert property (underflow && ctrl_q.autoWakeOnUnderflow
        |=> events_q.wakeRequest)
        else $error("no wake request on underflow");

    a_scan_launch: assert property (launchSeq |=> fieldOnSeq)
        else $error("scan did not switch field on");

    a_field_window: assert property (scanState_q == SCAN_FIELD && !timer3Expired
        |=> events_q.rfFieldOn)
        else $error("field dropped before timer 3 expired");

    a_card_found: assert property (scanCard |=> irqStatus_q.scanCard && events_q.stayActive)
        else $error("card found without interrupt or stay active");

    a_no_card: assert property (scanEmpty && ctrl_q.autoWakeOnUnderflow
        |=> events_q.powerDownRequest && !events_q.rfFieldOn)
        else $error("empty scan did not request power-down");

    a_count_read: assert property (setupPhase && !pwrite && hitCntLo
        |=> prdata_q[7:0] == $past(count_q[7:0]))
        else $error("count low byte read mismatch");
endmodule

// ===== shared/wkt_pkg.sv
/*
 * Types of the wake-up timer block.
 * Assumes wkt_regs.svh holds the numbers these types carry.
 */
package wkt_pkg;
    // control bits 5:0 in register order
    typedef struct packed {
        logic autoOscillatorTrim;
        logic autoCardPresenceScan;
        logic autoReloadOnZero;
        logic autoWakeOnUnderflow;
        logic [1:0] wakeTimerClockSelect;
    } wkt_ctrl_s;

    typedef struct packed {
        logic scanEmpty;
        logic scanCard;
        logic underflow;
    } wkt_irq_s;

    typedef struct packed {
        logic wakeRequest;
        logic powerDownRequest;
        logic stayActive;
        logic trimStart;
        logic timer3Start;
        logic rfFieldOn;
    } wkt_sys_s;

    typedef enum {SCAN_IDLE, SCAN_FIELD} wkt_scan_e;
endpackage

// ===== shared/wkt_regs.svh
/*
 * Register indices, field positions, reset values and prescaler counts of
 * the wake-up timer. Assumes byte address = index * 4 on a 32-bit APB bus.
 */
`ifndef WKT_REGS_SVH
`define WKT_REGS_SVH
// Overview of operation
// - control bit 7 shows running; writes start/stop only with qualifier set
// - control bit 6 qualifies a change of the running bit
// - auto-trim bit 5 starts an oscillator trim run at each underflow
// - auto-scan bit 4 launches a card presence scan at underflow
// - card found: raise interrupt and stay active
// - no card found: return to power-down when enabled
// - during auto scan the countdown restarts with no gap
// - RF field on-time is timer 3's programmed period
// - auto-reload bit 3 reloads at zero; otherwise, unless auto-scan bit 4 is set, count to zero and stop
// - every underflow sets the wake-up timer interrupt flag
// - auto-wake bit 2 wakes the chip at each underflow
// - bits 1:0 pick oscillator divide by 1, 8, 16 or 32
// - reload word from high and low bytes, loaded at each start
// - reload writes leave a running countdown alone until next start or restart at zero
// - live counter readable as high and low bytes

`define WKT_IDX_CTRL 8'h23
`define WKT_IDX_RELOAD_HI 8'h24
`define WKT_IDX_RELOAD_LO 8'h25
`define WKT_IDX_COUNT_HI 8'h26
`define WKT_IDX_COUNT_LO 8'h27
`define WKT_IDX_IRQ_STATUS 8'h30
`define WKT_IDX_IRQ_MASK 8'h31
`define WKT_IDX_SCAN_STATUS 8'h32

`define WKT_BIT_ACTIVE 7
`define WKT_BIT_QUALIFIER 6

`define WKT_CTRL_RESET 6'h00
`define WKT_RELOAD_RESET 16'h0000
`define WKT_IRQ_RESET 3'h0

`define WKT_DIV_1_LAST 5'h00
`define WKT_DIV_8_LAST 5'h07
`define WKT_DIV_16_LAST 5'h0F
`define WKT_DIV_32_LAST 5'h1F
`endif

// ===== verification/wkt_testbench.sv
/*
 * Self-checking bench of the wake-up timer: APB access, countdown,
 * prescaler, interrupt and card presence scan.
 * Assumes wkt_pkg, wkt_regs.svh and wkt_wake_timer are compiled first.
 */
`include "wkt_regs.svh"
module testbench import wkt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clockEnable = 1'b1;
    logic lfoClockPin = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic timer3Expired = 1'b0;
    logic cardPresent = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] first;
    logic pready;
    logic pslverr;
    logic err;
    logic irq;
    logic [15:0] rl;
    wkt_sys_s systemEvents;
    int miscompares = 0;
    int totalChecks = 0;
    int wakeCnt = 0;
    int trimCnt = 0;
    int t3Cnt = 0;
    int pdCnt = 0;
    int cyc;
    int p;

    wkt_wake_timer dut (.clock(clock), .reset(reset), .clockEnable(clockEnable),
        .lfoClockPin(lfoClockPin), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer3Expired(timer3Expired), .cardPresent(cardPresent),
        .systemEvents(systemEvents), .irq(irq));

    always #5 clock = ~clock;

    // oscillator of 8 clocks a period, well above the 3-cycle minimum
    always begin
        repeat (4) @(posedge clock);
        lfoClockPin <= ~lfoClockPin;
    end

    always @(posedge clock) begin
        if (systemEvents.wakeRequest === 1'b1) wakeCnt++;
        if (systemEvents.trimStart === 1'b1) trimCnt++;
        if (systemEvents.timer3Start === 1'b1) t3Cnt++;
        if (systemEvents.powerDownRequest === 1'b1) pdCnt++;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task conclude;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task fault(input string msg);
        miscompares++;
        $display("MISMATCH %0t %s", $time, msg);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        totalChecks++;
        if (got !== exp) fault(msg);
    endtask

    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fault("bus timeout");
            conclude();
        end
    endtask

    task rdchk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp, msg);
    endtask

    // sel 0 waits for irq, 1 for the RF field
    task waitHigh(input int sel, input int limit);
        cyc = 0;
        while ((sel ? systemEvents.rfFieldOn : irq) !== 1'b1 && cyc < limit) begin
            @(posedge clock);
            cyc++;
        end
        if (cyc >= limit) begin
            fault("wait timeout");
            conclude();
        end
    endtask

    task startTimer(input logic [15:0] r, input logic [5:0] bits);
        apb(1'b1, `WKT_IDX_RELOAD_HI, {24'h0, r[15:8]});
        apb(1'b1, `WKT_IDX_RELOAD_LO, {24'h0, r[7:0]});
        apb(1'b1, `WKT_IDX_CTRL, {24'h0, 2'b11, bits});
    endtask

    task stopClear;
        apb(1'b1, `WKT_IDX_CTRL, 32'h40);
        apb(1'b1, `WKT_IDX_IRQ_STATUS, 32'h07);
    endtask

    function automatic int divOf(input int s);
        return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 16 : 32;
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(43));
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rdchk(`WKT_IDX_CTRL, 32'h0, "ctrl reset");
        rdchk(`WKT_IDX_RELOAD_HI, 32'h0, "reload reset");
        rdchk(`WKT_IDX_COUNT_LO, 32'h0, "count reset");
        apb(1'b0, 8'h3F, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped no error");
        apb(1'b1, `WKT_IDX_CTRL, 32'h80);
        rdchk(`WKT_IDX_CTRL, 32'h0, "run without qualifier");
        apb(1'b1, `WKT_IDX_IRQ_MASK, 32'h07);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            rl = 16'($urandom_range(4, 2));
            p = divOf(s) * 8;
            startTimer(rl, 6'(s));
            rdchk(`WKT_IDX_CTRL, 32'h80 | s, "running after start");
            waitHigh(0, 2000);
            chk({31'h0, cyc + 12 >= (rl - 1) * p && cyc <= rl * p + 12}, 1, "period");
            rdchk(`WKT_IDX_CTRL, 32'(s), "one-shot stop");
            rdchk(`WKT_IDX_COUNT_LO, 32'h0, "count at zero");
            rdchk(`WKT_IDX_IRQ_STATUS, 32'h1, "underflow flag");
            apb(1'b1, `WKT_IDX_IRQ_STATUS, 32'h1);
            @(posedge clock);
            chk({31'h0, irq}, 32'h0, "irq not cleared");
        end
        $display("test prescaler done");
        startTimer(16'h0120, 6'h08);
        apb(1'b1, `WKT_IDX_RELOAD_HI, 32'h0);
        apb(1'b1, `WKT_IDX_RELOAD_LO, 32'h3);
        rdchk(`WKT_IDX_COUNT_HI, 32'h1, "reload disturbed count");
        apb(1'b0, `WKT_IDX_COUNT_LO, 32'h0);
        first = rd;
        // enable low must hold the count; only the read cycles may tick
        clockEnable <= 1'b0;
        repeat (40) @(posedge clock);
        clockEnable <= 1'b1;
        apb(1'b0, `WKT_IDX_COUNT_LO, 32'h0);
        chk({31'h0, first - rd <= 32'h2}, 32'h1, "enable low did not freeze");
        first = rd;
        repeat (40) @(posedge clock);
        apb(1'b0, `WKT_IDX_COUNT_LO, 32'h0);
        chk({31'h0, rd < first}, 32'h1, "count frozen");
        waitHigh(0, 3000);
        rdchk(`WKT_IDX_CTRL, 32'h88, "auto reload stopped");
        rdchk(`WKT_IDX_COUNT_HI, 32'h0, "new reload unused");
        stopClear();
        $display("test reload done");
        wakeCnt = 0;
        trimCnt = 0;
        startTimer(16'h0002, 6'h24);
        waitHigh(0, 200);
        repeat (2) @(posedge clock);
        chk(wakeCnt, 1, "wake pulses");
        chk(trimCnt, 1, "trim pulses");
        stopClear();
        $display("test wake done");
        // cp 2: auto-wake cleared, so an empty scan keeps the chip up
        for (int cp = 0; cp < 3; cp++) begin
            t3Cnt = 0;
            pdCnt = 0;
            startTimer(16'h0030, (cp == 2) ? 6'h10 : 6'h14);
            waitHigh(1, 1000);
            repeat (6) @(posedge clock);
            chk(t3Cnt, 1, "scan launch");
            chk({31'h0, systemEvents.rfFieldOn}, 1, "field dropped early");
            timer3Expired <= 1'b1;
            cardPresent <= (cp == 1);
            @(posedge clock);
            timer3Expired <= 1'b0;
            cardPresent <= 1'($urandom_range(1, 0));
            repeat (3) @(posedge clock);
            chk({31'h0, systemEvents.rfFieldOn}, 0, "field stuck");
            if (cp == 1) begin
                chk({31'h0, systemEvents.stayActive}, 1, "stay active");
                chk(pdCnt, 0, "power down on card");
                rdchk(`WKT_IDX_IRQ_STATUS, 32'h3, "card flag");
                rdchk(`WKT_IDX_SCAN_STATUS, 32'h2, "scan result");
            end else begin
                chk(pdCnt, (cp == 0) ? 1 : 0, "power down");
                chk({31'h0, systemEvents.stayActive}, (cp == 2) ? 1 : 0, "stay after empty");
                rdchk(`WKT_IDX_IRQ_STATUS, 32'h5, "empty flag");
            end
            rdchk(`WKT_IDX_CTRL, (cp == 2) ? 32'h90 : 32'h94, "scan restart");
            apb(1'b0, `WKT_IDX_COUNT_LO, 32'h0);
            chk({31'h0, rd > 32'h20}, 32'h1, "no reload gap");
            stopClear();
        end
        $display("test scan done");
        conclude();
    end
endmodule
